// ===== verilog/sfsp_pkg.sv
package sfsp_pkg;

  // Register bus geometry and byte offsets.
  localparam int          AXI_ADDR_W   = 8;
  localparam logic [7:0]  OFF_CTRL     = 8'h00;
  localparam logic [7:0]  OFF_STATUS   = 8'h04;
  localparam logic [7:0]  OFF_OPCODE   = 8'h08;
  localparam logic [7:0]  OFF_ADDR     = 8'h0c;
  localparam logic [7:0]  OFF_WDATA    = 8'h10;
  localparam logic [7:0]  OFF_RDATA    = 8'h14;
  localparam logic [7:0]  OFF_IRQ_STS  = 8'h18;
  localparam logic [7:0]  OFF_IRQ_MASK = 8'h1c;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  // Flash status byte layout and its reset value.
  localparam int          STS_BUSY_BIT = 0;
  localparam int          STS_WRITE_EN_BIT = 1;
  localparam int          STS_PROT_LSB = 2;
  localparam int          STS_AUTO_INC_BIT = 6;
  localparam int          STS_LOCK_BIT = 7;
  localparam int          STS_HOLD_BIT = 8;
  localparam int          STS_SEL_BIT  = 9;
  localparam logic [3:0]  PROT_RST     = 4'h7;
  localparam logic        LOCK_RST     = 1'b0;

  // Control register and interrupt bits.
  localparam int          CTRL_DONE_BIT = 0;
  localparam int          IRQ_W         = 4;
  localparam int          IRQ_PROG_BIT  = 0;
  localparam int          IRQ_ERASE_BIT = 1;
  localparam int          IRQ_WSTS_BIT  = 2;
  localparam int          IRQ_WREJ_BIT  = 3;
  localparam logic [7:0]  RDATA_RST     = 8'hff;

  // Serial commands.
  localparam logic [7:0]  CMD_WRITE_STATUS = 8'h01;
  localparam logic [7:0]  CMD_BYTE_PROG    = 8'h02;
  localparam logic [7:0]  CMD_READ         = 8'h03;
  localparam logic [7:0]  CMD_WRITE_DIS    = 8'h04;
  localparam logic [7:0]  CMD_READ_STATUS  = 8'h05;
  localparam logic [7:0]  CMD_WRITE_EN     = 8'h06;
  localparam logic [7:0]  CMD_ERASE_4K     = 8'h20;
  localparam logic [7:0]  CMD_ERASE_32K    = 8'h52;
  localparam logic [7:0]  CMD_AUTO_INC     = 8'had;
  localparam logic [7:0]  CMD_ERASE_64K    = 8'hd8;

  // Erase granularity in bytes.
  localparam logic [23:0] SECTOR_BYTES    = 24'h001000;
  localparam logic [23:0] BLOCK32_BYTES   = 24'h008000;
  localparam logic [23:0] BLOCK64_BYTES   = 24'h010000;
  localparam logic [1:0]  ADDR_LAST_BYTE  = 2'h2;
  localparam logic [2:0]  BIT_LAST        = 3'h7;

  // Synchroniser reset image, ordered {wp_n, hold_n, si, cs_n, sck}.
  localparam logic [4:0]  PIN_RST = 5'h1a;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CMD  = 5'b00010,
    ST_ADDR = 5'b00100,
    ST_DATA = 5'b01000,
    ST_OUT  = 5'b10000
  } sfsp_state_type;

endpackage

// ===== verilog/sfsp_sync.sv
`timescale 1ns/1ps
module sfsp_sync #(
  parameter int           WIDTH   = 5,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] ff1_r;
  logic [WIDTH-1:0] ff2_r;
  logic [WIDTH-1:0] ff3_r;
  logic [WIDTH-1:0] dout_r;
  logic [WIDTH-1:0] dout_nxt;

  // A bit only moves once the second and third stages agree.
  assign dout_nxt = (ff3_r & ~(ff2_r ^ ff3_r)) | (dout_r & (ff2_r ^ ff3_r));
  assign dout     = dout_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ff1_r  <= RST_VAL;
      ff2_r  <= RST_VAL;
      ff3_r  <= RST_VAL;
      dout_r <= RST_VAL;
    end else begin
      ff1_r  <= din;
      ff2_r  <= ff1_r;
      ff3_r  <= ff2_r;
      dout_r <= dout_nxt;
    end
  end

endmodule

// ===== verilog/sfsp_top.sv
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module sfsp_top #(
  parameter int ADDR_W = sfsp_pkg::AXI_ADDR_W
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              spi_sck,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_si,
  input  wire logic              spi_hold_n,
  input  wire logic              spi_wp_n,
  output logic                   spi_so,
  output logic                   spi_so_oe_n,
  output logic                   irq
);

  logic [4:0]                 pin_f;
  logic                       sck_f;
  logic                       cs_n_f;
  logic                       si_f;
  logic                       hold_n_f;
  logic                       wp_n_f;
  logic                       sck_q_r;
  logic                       cs_n_q_r;
  logic                       hold_r;
  sfsp_pkg::sfsp_state_type   state_r;
  sfsp_pkg::sfsp_state_type   state_nxt;
  logic [2:0]                 bit_cnt_r;
  logic [1:0]                 byte_cnt_r;
  logic [7:0]                 sh_in_r;
  logic [7:0]                 sh_out_r;
  logic [7:0]                 sh_out_nxt;
  logic [7:0]                 opcode_r;
  logic [7:0]                 opcode_nxt;
  logic [23:0]                addr_r;
  logic [23:0]                addr_nxt;
  logic [7:0]                 wdata_r;
  logic                       busy_r;
  logic                       busy_nxt;
  logic                       write_en_r;
  logic                       write_en_nxt;
  logic                       auto_inc_r;
  logic                       auto_inc_nxt;
  logic [3:0]                 prot_r;
  logic [3:0]                 prot_nxt;
  logic                       lock_r;
  logic                       lock_nxt;
  logic [sfsp_pkg::IRQ_W-1:0] ev;
  logic [sfsp_pkg::IRQ_W-1:0] irq_sts_r;
  logic [sfsp_pkg::IRQ_W-1:0] irq_mask_r;
  logic [7:0]                 rdata_byte_r;
  logic                       so_r;
  logic                       so_pin_r;
  logic                       so_oe_n_r;
  logic                       aw_held_r;
  logic                       w_held_r;
  logic [ADDR_W-1:0]          aw_addr_r;
  logic [31:0]                w_data_r;
  logic [3:0]                 w_strb_r;
  logic                       bvalid_r;
  logic [1:0]                 bresp_r;
  logic                       rvalid_r;
  logic [1:0]                 rresp_r;
  logic [31:0]                rdata_r;

  // Keeps the lowest address of the region that an erase of this size covers.
  function automatic logic [23:0] align_down(input logic [23:0] a, input logic [23:0] size);
    align_down = a & ~(size - 24'h000001);
  endfunction

  function automatic logic is_addr(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    is_addr = (a == off[ADDR_W-1:0]);
  endfunction

  sfsp_sync #(
    .WIDTH   (5),
    .RST_VAL (sfsp_pkg::PIN_RST)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({spi_wp_n, spi_hold_n, spi_si, spi_cs_n, spi_sck}),
    .dout    (pin_f)
  );

  assign sck_f    = pin_f[0];
  assign cs_n_f   = pin_f[1];
  assign si_f     = pin_f[2];
  assign hold_n_f = pin_f[3];
  assign wp_n_f   = pin_f[4];

  // Both clock modes only differ in idle level; edges are found the same way.
  wire sck_rise  = sck_f & ~sck_q_r & ~cs_n_f & ~hold_r;
  wire sck_fall  = ~sck_f & sck_q_r & ~cs_n_f & ~hold_r;
  wire cs_fall   = ~cs_n_f & cs_n_q_r;
  wire cs_rise   = cs_n_f & ~cs_n_q_r;
  wire [7:0] rx_byte   = {sh_in_r[6:0], si_f};
  wire       byte_done = sck_rise & (bit_cnt_r == sfsp_pkg::BIT_LAST);
  wire [7:0] status_byte = {lock_r, auto_inc_r, prot_r, write_en_r, busy_r};
  wire       wsts_allowed = wp_n_f | ~lock_r;
  wire       is_erase = (opcode_r == sfsp_pkg::CMD_ERASE_4K) | (opcode_r == sfsp_pkg::CMD_ERASE_32K) |
                        (opcode_r == sfsp_pkg::CMD_ERASE_64K);
  wire [23:0] erase_size = (opcode_r == sfsp_pkg::CMD_ERASE_4K)  ? sfsp_pkg::SECTOR_BYTES :
                           (opcode_r == sfsp_pkg::CMD_ERASE_32K) ? sfsp_pkg::BLOCK32_BYTES :
                                                                   sfsp_pkg::BLOCK64_BYTES;
  wire cmd_allowed = busy_r ? (rx_byte == sfsp_pkg::CMD_READ_STATUS) :
                     auto_inc_r ? (rx_byte == sfsp_pkg::CMD_READ_STATUS) | (rx_byte == sfsp_pkg::CMD_AUTO_INC) |
                                  (rx_byte == sfsp_pkg::CMD_WRITE_DIS) : 1'b1;

  // Register bus decode.
  wire wr_fire   = aw_held_r & w_held_r & ~bvalid_r;
  wire wr_ctrl   = wr_fire & w_strb_r[0] & is_addr(aw_addr_r, sfsp_pkg::OFF_CTRL);
  wire wr_rdata  = wr_fire & w_strb_r[0] & is_addr(aw_addr_r, sfsp_pkg::OFF_RDATA);
  wire wr_irqs   = wr_fire & w_strb_r[0] & is_addr(aw_addr_r, sfsp_pkg::OFF_IRQ_STS);
  wire wr_irqm   = wr_fire & w_strb_r[0] & is_addr(aw_addr_r, sfsp_pkg::OFF_IRQ_MASK);
  wire wr_hit    = is_addr(aw_addr_r, sfsp_pkg::OFF_CTRL) | is_addr(aw_addr_r, sfsp_pkg::OFF_RDATA) |
                   is_addr(aw_addr_r, sfsp_pkg::OFF_IRQ_STS) | is_addr(aw_addr_r, sfsp_pkg::OFF_IRQ_MASK);
  wire op_done   = wr_ctrl & w_data_r[sfsp_pkg::CTRL_DONE_BIT] & busy_r;
  wire rd_fire   = s_axi_arvalid & ~rvalid_r;
  wire rd_hit    = is_addr(s_axi_araddr, sfsp_pkg::OFF_CTRL) | is_addr(s_axi_araddr, sfsp_pkg::OFF_STATUS) |
                   is_addr(s_axi_araddr, sfsp_pkg::OFF_OPCODE) | is_addr(s_axi_araddr, sfsp_pkg::OFF_ADDR) |
                   is_addr(s_axi_araddr, sfsp_pkg::OFF_WDATA) | is_addr(s_axi_araddr, sfsp_pkg::OFF_RDATA) |
                   is_addr(s_axi_araddr, sfsp_pkg::OFF_IRQ_STS) | is_addr(s_axi_araddr, sfsp_pkg::OFF_IRQ_MASK);
  wire [31:0] rd_val =
    is_addr(s_axi_araddr, sfsp_pkg::OFF_STATUS)   ? {22'h0, ~cs_n_f, hold_r, status_byte} :
    is_addr(s_axi_araddr, sfsp_pkg::OFF_OPCODE)   ? {24'h0, opcode_r} :
    is_addr(s_axi_araddr, sfsp_pkg::OFF_ADDR)     ? {8'h0, addr_r} :
    is_addr(s_axi_araddr, sfsp_pkg::OFF_WDATA)    ? {24'h0, wdata_r} :
    is_addr(s_axi_araddr, sfsp_pkg::OFF_RDATA)    ? {24'h0, rdata_byte_r} :
    is_addr(s_axi_araddr, sfsp_pkg::OFF_IRQ_STS)  ? {28'h0, irq_sts_r} :
    is_addr(s_axi_araddr, sfsp_pkg::OFF_IRQ_MASK) ? {28'h0, irq_mask_r} : 32'h0;

  // Serial sequence: next-state and side effects of each completed byte.
  always_comb begin
    state_nxt  = state_r;
    opcode_nxt = opcode_r;
    addr_nxt   = addr_r;
    sh_out_nxt = sh_out_r;
    busy_nxt   = busy_r;
    write_en_nxt = write_en_r;
    auto_inc_nxt = auto_inc_r;
    prot_nxt   = prot_r;
    lock_nxt   = lock_r;
    ev         = '0;
    if (sck_fall) begin
      sh_out_nxt = {sh_out_r[6:0], 1'b0};
    end
    if (byte_done) begin
      case (state_r)
        sfsp_pkg::ST_CMD: begin
          opcode_nxt = rx_byte;
          state_nxt  = sfsp_pkg::ST_IDLE;
          if (cmd_allowed) begin
            if (rx_byte == sfsp_pkg::CMD_READ_STATUS) begin
              state_nxt  = sfsp_pkg::ST_OUT;
              sh_out_nxt = status_byte;
            end else if (rx_byte == sfsp_pkg::CMD_WRITE_EN) begin
              write_en_nxt = 1'b1;
            end else if (rx_byte == sfsp_pkg::CMD_WRITE_DIS) begin
              write_en_nxt = 1'b0;
              auto_inc_nxt = 1'b0;
            end else if (rx_byte == sfsp_pkg::CMD_WRITE_STATUS && write_en_r) begin
              state_nxt = sfsp_pkg::ST_DATA;
            end else if (rx_byte == sfsp_pkg::CMD_AUTO_INC && auto_inc_r) begin
              state_nxt = sfsp_pkg::ST_DATA;
              addr_nxt  = addr_r + 24'h000001;
            end else if (rx_byte == sfsp_pkg::CMD_READ ||
                         (write_en_r && (rx_byte == sfsp_pkg::CMD_BYTE_PROG || rx_byte == sfsp_pkg::CMD_AUTO_INC ||
                                    rx_byte == sfsp_pkg::CMD_ERASE_4K || rx_byte == sfsp_pkg::CMD_ERASE_32K ||
                                    rx_byte == sfsp_pkg::CMD_ERASE_64K))) begin
              state_nxt = sfsp_pkg::ST_ADDR;
            end
          end
        end
        sfsp_pkg::ST_ADDR: begin
          addr_nxt = {addr_r[15:0], rx_byte};
          if (byte_cnt_r == sfsp_pkg::ADDR_LAST_BYTE) begin
            if (is_erase) begin
              addr_nxt  = align_down({addr_r[15:0], rx_byte}, erase_size);
              busy_nxt  = 1'b1;
              ev[sfsp_pkg::IRQ_ERASE_BIT] = 1'b1;
              state_nxt = sfsp_pkg::ST_IDLE;
            end else if (opcode_r == sfsp_pkg::CMD_READ) begin
              state_nxt  = sfsp_pkg::ST_OUT;
              sh_out_nxt = rdata_byte_r;
            end else begin
              state_nxt = sfsp_pkg::ST_DATA;
            end
          end
        end
        sfsp_pkg::ST_DATA: begin
          state_nxt = sfsp_pkg::ST_IDLE;
          if (opcode_r == sfsp_pkg::CMD_WRITE_STATUS) begin
            if (wsts_allowed) begin
              prot_nxt = rx_byte[sfsp_pkg::STS_PROT_LSB +: 4];
              lock_nxt = rx_byte[sfsp_pkg::STS_LOCK_BIT];
              write_en_nxt = 1'b0;
              ev[sfsp_pkg::IRQ_WSTS_BIT] = 1'b1;
            end else begin
              ev[sfsp_pkg::IRQ_WREJ_BIT] = 1'b1;
            end
          end else begin
            busy_nxt = 1'b1;
            auto_inc_nxt = (opcode_r == sfsp_pkg::CMD_AUTO_INC);
            ev[sfsp_pkg::IRQ_PROG_BIT] = 1'b1;
          end
        end
        sfsp_pkg::ST_OUT: begin
          if (opcode_r == sfsp_pkg::CMD_READ) begin
            sh_out_nxt = rdata_byte_r;
            addr_nxt   = addr_r + 24'h000001;
          end else begin
            sh_out_nxt = status_byte;
          end
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
    end
    if (cs_fall && !hold_r) begin
      state_nxt = sfsp_pkg::ST_CMD;
    end
    if (cs_rise) begin
      state_nxt = sfsp_pkg::ST_IDLE;
    end
    if (op_done) begin
      busy_nxt = 1'b0;
      write_en_nxt = auto_inc_r;
    end
  end

  // Serial-side registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_q_r    <= 1'b0;
      cs_n_q_r   <= 1'b1;
      hold_r     <= 1'b0;
      state_r    <= sfsp_pkg::ST_IDLE;
      bit_cnt_r  <= 3'h0;
      byte_cnt_r <= 2'h0;
      sh_in_r    <= 8'h00;
      sh_out_r   <= 8'h00;
      opcode_r   <= 8'h00;
      addr_r     <= 24'h000000;
      wdata_r    <= 8'h00;
      busy_r     <= 1'b0;
      write_en_r <= 1'b0;
      auto_inc_r <= 1'b0;
      prot_r     <= sfsp_pkg::PROT_RST;
      lock_r     <= sfsp_pkg::LOCK_RST;
      so_r       <= 1'b0;
    end else begin
      sck_q_r  <= sck_f;
      cs_n_q_r <= cs_n_f;
      if (cs_n_f) begin
        hold_r <= hold_r & ~hold_n_f;
      end else if (!sck_f) begin
        hold_r <= ~hold_n_f;
      end
      state_r  <= state_nxt;
      opcode_r <= opcode_nxt;
      addr_r   <= addr_nxt;
      sh_out_r <= sh_out_nxt;
      busy_r   <= busy_nxt;
      write_en_r <= write_en_nxt;
      auto_inc_r <= auto_inc_nxt;
      prot_r   <= prot_nxt;
      lock_r   <= lock_nxt;
      if (cs_fall || cs_rise) begin
        bit_cnt_r  <= 3'h0;
        byte_cnt_r <= 2'h0;
      end else if (sck_rise) begin
        sh_in_r   <= rx_byte;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (byte_done && state_r == sfsp_pkg::ST_ADDR) begin
          byte_cnt_r <= byte_cnt_r + 2'h1;
        end else if (byte_done) begin
          byte_cnt_r <= 2'h0;
        end
      end
      if (byte_done && state_r == sfsp_pkg::ST_DATA && opcode_r != sfsp_pkg::CMD_WRITE_STATUS) begin
        wdata_r <= rx_byte;
      end
      if (sck_fall) begin
        so_r <= sh_out_r[7];
      end
    end
  end

  // Output pin: data while reading, ready/busy while deselected in increment mode.
  wire so_drive = ~cs_n_f ? (~hold_r & (state_r == sfsp_pkg::ST_OUT)) : auto_inc_r;
  wire so_val   = cs_n_f ? ~busy_r : so_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      so_pin_r  <= 1'b0;
      so_oe_n_r <= 1'b1;
    end else begin
      so_pin_r  <= so_val;
      so_oe_n_r <= ~so_drive;
    end
  end

  assign spi_so      = so_pin_r;
  assign spi_so_oe_n = so_oe_n_r;

  // Interrupts: a new event wins over a write-one clear in the same cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_sts_r    <= '0;
      irq_mask_r   <= '0;
      rdata_byte_r <= sfsp_pkg::RDATA_RST;
    end else begin
      irq_sts_r <= (irq_sts_r & ~(wr_irqs ? w_data_r[sfsp_pkg::IRQ_W-1:0] : '0)) | ev;
      if (wr_irqm) begin
        irq_mask_r <= w_data_r[sfsp_pkg::IRQ_W-1:0];
      end
      if (wr_rdata) begin
        rdata_byte_r <= w_data_r[7:0];
      end
    end
  end

  assign irq = |(irq_sts_r & irq_mask_r);

  // AXI4-Lite slave.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= '0;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
      bvalid_r  <= 1'b0;
      bresp_r   <= sfsp_pkg::RESP_OKAY;
      rvalid_r  <= 1'b0;
      rresp_r   <= sfsp_pkg::RESP_OKAY;
      rdata_r   <= 32'h0;
    end else begin
      if (s_axi_awvalid && !aw_held_r) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_r) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_r <= 1'b0;
        w_held_r  <= 1'b0;
        bvalid_r  <= 1'b1;
        bresp_r   <= wr_hit ? sfsp_pkg::RESP_OKAY : sfsp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_val;
        rresp_r  <= rd_hit ? sfsp_pkg::RESP_OKAY : sfsp_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  assign s_axi_awready = ~aw_held_r;
  assign s_axi_wready  = ~w_held_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = ~rvalid_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rdata   = rdata_r;
  assign s_axi_rresp   = rresp_r;

endmodule

// ===== test/sfsp_chk.sv
`timescale 1ns/1ps
module sfsp_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_hold_n,
  input wire logic spi_so,
  input wire logic spi_so_oe_n,
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |=> !s_axi_awready ##1 s_axi_bvalid) else $error("late write answer");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid && s_axi_awready && s_axi_wready) else $error("write answer not closed");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("late read");
  a_r_done: assert property (s_axi_rvalid && s_axi_rready
    |=> !s_axi_rvalid && s_axi_arready) else $error("read not closed");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_reset_quiet: assert property ($rose(aresetn)
    |-> spi_so_oe_n && !irq && !s_axi_bvalid && !s_axi_rvalid) else $error("outputs active after reset");
  a_hold_float: assert property (!spi_cs_n && !spi_hold_n && !spi_sck [*8]
    |-> ##2 spi_so_oe_n) else $error("output driven in hold");
  a_so_on_fall: assert property (!spi_cs_n && spi_sck [*8]
    |=> $stable(spi_so)) else $error("output moved with clock high");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_irq: cover property ($rose(irq));
  c_drive: cover property ($fell(spi_so_oe_n));
endmodule

bind sfsp_top sfsp_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .spi_sck,
  .spi_cs_n, .spi_hold_n, .spi_so, .spi_so_oe_n, .irq);

// ===== test/sfsp_host.sv
`timescale 1ns/1ps
module sfsp_host (
  output logic     spi_sck,
  output logic     spi_cs_n,
  output logic     spi_si,
  output logic     spi_hold_n,
  input wire logic spi_so,
  input wire logic spi_so_oe_n
);
  logic m3 = 1'b0;
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
    spi_si = 1'b0;
    spi_hold_n = 1'b1;
  end
  // The clock rests at the idle level of the chosen mode while deselected.
  // A frame begins just after a clock edge, so pin changes never meet a sampling edge.
  task automatic start(input logic m);
    #1;
    m3 = m;
    spi_sck = m;
    #80 spi_cs_n = 1'b0;
    #80;
  endtask
  task automatic xfer(input logic [7:0] d, input int hb, input int nb, output logic [7:0] q);
    q = 8'h00;
    for (int i = 7; i > 7 - nb; i--) begin
      spi_sck = 1'b0;
      spi_si = d[i];
      if (i == hb) begin
        spi_hold_n = 1'b0;
        #80 spi_sck = 1'b1;
        #80 spi_sck = 1'b0;
        spi_hold_n = 1'b1;
      end
      #80 spi_sck = 1'b1;
      q[i] = spi_so_oe_n ? ~spi_si : spi_so;
      #80;
    end
  endtask
  task automatic stop;
    if (!m3) spi_sck = 1'b0;
    #80 spi_cs_n = 1'b1;
    spi_si = ~spi_si;
    #160;
  endtask
  task automatic abort;
    spi_sck = 1'b0;
    spi_hold_n = 1'b0;
    #160 spi_cs_n = 1'b1;
    #160 spi_hold_n = 1'b1;
    #160;
  endtask
endmodule

// ===== test/sfsp_tb.sv
`timescale 1ns/1ps
module testbench;
  logic        aclk = 1'b0, aresetn = 1'b0, m3 = 1'b0, spi_wp_n = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, q;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        spi_sck, spi_cs_n, spi_si, spi_hold_n, spi_so, spi_so_oe_n, irq;
  int          n_fail = 0, checks = 0;
  always #2.5 aclk = ~aclk;
  sfsp_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .spi_sck, .spi_cs_n, .spi_si,
    .spi_hold_n, .spi_wp_n, .spi_so, .spi_so_oe_n, .irq);
  sfsp_host host (.spi_sck, .spi_cs_n, .spi_si, .spi_hold_n, .spi_so, .spi_so_oe_n);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e = 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    chk(32'(r), 32'(e));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    if (er == 2'h0) chk(d, e);
    chk(32'(r), 32'(er));
  endtask
  task automatic fr(input logic [39:0] b, input int n, input int hb = 9);
    host.start(m3);
    for (int k = 0; k < n; k++) host.xfer(b[39-8*k -: 8], hb, 8, q);
    host.stop();
    @(posedge aclk);
  endtask
  task automatic sts(input logic [7:0] e, input int hb = 9);
    fr({8'h05, 32'h0}, 2, hb);
    chk(32'(q), 32'(e));
  endtask
  task automatic t_regs;
    rd(sfsp_pkg::OFF_STATUS, 32'h1c);
    rd(8'h20, 32'h0, sfsp_pkg::RESP_SLVERR);
    axw(sfsp_pkg::OFF_STATUS, 32'h0, sfsp_pkg::RESP_SLVERR);
  endtask
  task automatic t_modes;
    for (int m = 0; m < 2; m++) begin
      m3 = m[0];
      sts(8'h1c);
      fr({8'h06, 32'h0}, 1);
      sts(8'h1e);
      fr({8'h04, 32'h0}, 1);
    end
    m3 = 1'b0;
  endtask
  task automatic t_lock;
    fr({8'h06, 32'h0}, 1);
    fr({8'h01, 8'h80, 24'h0}, 2);
    sts(8'h80);
    chk(32'(irq), 32'h0);
    rd(sfsp_pkg::OFF_IRQ_STS, 32'h4);
    spi_wp_n <= 1'b0;
    fr({8'h06, 32'h0}, 1);
    fr({8'h01, 8'h00, 24'h0}, 2);
    sts(8'h82);
    rd(sfsp_pkg::OFF_IRQ_STS, 32'hc);
    spi_wp_n <= 1'b1;
    fr({8'h01, 8'h00, 24'h0}, 2);
    sts(8'h00);
    axw(sfsp_pkg::OFF_IRQ_STS, 32'hf);
  endtask
  task automatic t_erase;
    logic [7:0]  c[3] = '{8'h20, 8'h52, 8'hd8};
    logic [23:0] e[3] = '{24'h123000, 24'h120000, 24'h120000};
    axw(sfsp_pkg::OFF_IRQ_MASK, 32'hf);
    for (int i = 0; i < 3; i++) begin
      fr({8'h06, 32'h0}, 1);
      fr({c[i], 24'h123456, 8'h0}, 4);
      sts(8'h03);
      chk(32'(irq), 32'h1);
      rd(sfsp_pkg::OFF_ADDR, {8'h0, e[i]});
      axw(sfsp_pkg::OFF_CTRL, 32'h1);
      axw(sfsp_pkg::OFF_IRQ_STS, 32'hf);
      chk(32'(irq), 32'h0);
    end
  endtask
  task automatic t_prog;
    fr({8'h06, 32'h0}, 1);
    fr({8'h02, 24'h000010, 8'ha5}, 5);
    rd(sfsp_pkg::OFF_WDATA, 32'ha5);
    chk(32'(irq), 32'h1);
    axw(sfsp_pkg::OFF_CTRL, 32'h1);
    axw(sfsp_pkg::OFF_IRQ_STS, 32'hf);
    axw(sfsp_pkg::OFF_RDATA, 32'h5a);
    fr({8'h03, 24'h000200, 8'h0}, 5);
    chk(32'(q), 32'h5a);
    rd(sfsp_pkg::OFF_ADDR, 32'h201);
  endtask
  task automatic t_auto_inc;
    fr({8'h06, 32'h0}, 1);
    fr({8'had, 24'h000100, 8'h11}, 5);
    chk(32'({spi_so_oe_n, spi_so}), 32'h0);
    sts(8'h43);
    axw(sfsp_pkg::OFF_CTRL, 32'h1);
    repeat (4) @(posedge aclk);
    chk(32'({spi_so_oe_n, spi_so}), 32'h1);
    fr({8'had, 8'h22, 24'h0}, 2);
    rd(sfsp_pkg::OFF_ADDR, 32'h101);
    axw(sfsp_pkg::OFF_CTRL, 32'h1);
    fr({8'h04, 32'h0}, 1);
    chk(32'(spi_so_oe_n), 32'h1);
    sts(8'h00);
    axw(sfsp_pkg::OFF_IRQ_STS, 32'hf);
  endtask
  task automatic t_hold;
    sts(8'h00, 4);
    host.start(m3);
    host.xfer(8'h06, 9, 4, q);
    fork
      host.abort();
      begin
        repeat (20) @(posedge aclk);
        rd(sfsp_pkg::OFF_STATUS, 32'h300);
      end
    join
    fr({8'h06, 32'h0}, 1);
    sts(8'h02);
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    t_regs();
    t_modes();
    t_lock();
    t_erase();
    t_prog();
    t_auto_inc();
    t_hold();
    close_out();
  end
  initial begin
    #400000;
    n_fail++;
    close_out();
  end
endmodule
